// ### hdl/host_device_multiplexer.sv
`timescale 1ns/1ps
`default_nettype none
module host_device_multiplexer
(
	input  wire logic                          clk,
	input  wire logic                          sys_rst,
	input  wire logic                          host_send_request,
	input  wire logic                          response_ack_in,
	output logic                               response_ack_out,
	output logic                               response_ack_oe,
	input  wire logic                          data_valid_in,
	output logic                               data_valid_out,
	output logic                               data_valid_oe,
	input  wire logic [1:0]                    function_code_in,
	output logic [1:0]                         function_code_out,
	output logic [1:0]                         function_code_oe,
	input  wire logic [mux_pkg::DATA_W-1:0]    data_in,
	output logic [mux_pkg::DATA_W-1:0]         data_out,
	output logic [mux_pkg::DATA_W-1:0]         data_oe,
	output logic                               device_send_request,
	output logic                               cmd_strobe,
	output logic [mux_pkg::SEL_W-1:0]          cmd_select,
	output logic [mux_pkg::CONTENT_W-1:0]      cmd_content,
	output logic                               acq_word_strobe,
	output logic                               display_word_strobe,
	output logic [mux_pkg::DATA_W-1:0]         word_data,
	input  wire logic                          watchdog_timeout,
	input  wire logic                          iface_data_avail,
	input  wire logic                          iface_done,
	input  wire logic [mux_pkg::DATA_W-1:0]    iface_byte,
	input  wire logic                          iface_byte_valid,
	output logic                               iface_byte_ready,
	output logic                               next_byte_pulse,
	output logic                               iface_reset,
	output logic                               data_ready,
	output logic                               status_jam
);
	typedef enum logic [2:0] {IDLE, HOST_ACK, HOST_STROBE, HOST_RELEASE,
		DEV_OFFER, DEV_HOLD} state_e;
	typedef struct packed
	{
		state_e                              state;
		logic [mux_pkg::CNT_W-1:0]           cnt;        // strobe and reset timer
		logic                                ack;        // our response_ack
		logic                                dv;         // our data_valid
		logic                                drive;      // data and code enables
		logic [1:0]                          fc;         // code driven out
		logic [mux_pkg::DATA_W-1:0]          dout;       // byte driven out
		logic                                send_req;   // device_send_request
		logic                                cmd_stb;
		logic [mux_pkg::SEL_W-1:0]           sel;
		logic [mux_pkg::CONTENT_W-1:0]       content;
		logic                                acq_stb;
		logic                                disp_stb;
		logic [mux_pkg::DATA_W-1:0]          word;
		logic                                jam;        // status jam flag
		logic                                wd_seen;    // timeout since last status
		logic                                rdy;        // data ready flag
		logic                                nbp;        // next byte one-shot
		logic                                is_status;  // transfer carries status
		logic                                pop;        // release buffered byte
		logic                                if_rst;     // interface reset pulse
	} mux_s;
	mux_s r;
	mux_s next_r;
	localparam mux_s RESET_R = '{state: IDLE, if_rst: 1'b1, default: '0}; // reset image
	logic                         req_f;     // filtered host request
	logic                         ack_f;     // filtered host ack
	logic                         dv_f;      // filtered host data_valid
	logic [mux_pkg::DATA_W-1:0]   buf_data;
	logic                         buf_valid;
	logic                         buf_in_ready;

	// status byte: watchdog cause, data ready, last selection
	function automatic logic [mux_pkg::DATA_W-1:0] status_byte(input mux_s s);
		logic [mux_pkg::DATA_W-1:0] b;
		b = '0;
		b[mux_pkg::STAT_WATCHDOG_BIT] = s.wd_seen;
		b[mux_pkg::STAT_READY_BIT] = s.rdy;
		b[mux_pkg::SEL_W-1:0] = s.sel;
		return b;
	endfunction

	// synchronise and filter each handshake input
	input_filter req_filter
	(
		.clk      (clk),
		.sys_rst  (sys_rst),
		.raw      (host_send_request),
		.filtered (req_f)
	);
	input_filter ack_filter
	(
		.clk      (clk),
		.sys_rst  (sys_rst),
		.raw      (response_ack_in),
		.filtered (ack_f)
	);
	input_filter dv_filter
	(
		.clk      (clk),
		.sys_rst  (sys_rst),
		.raw      (data_valid_in),
		.filtered (dv_f)
	);

	// bytes from the sending interface wait here for the host
	byte_buffer out_buffer
	(
		.clk       (clk),
		.sys_rst   (sys_rst),
		.in_data   (iface_byte),
		.in_valid  (iface_byte_valid && r.rdy),
		.in_ready  (buf_in_ready),
		.out_data  (buf_data),
		.out_valid (buf_valid),
		.out_ready (r.pop)
	);

	// handshake sequencer and flags
	always_comb
	begin
		next_r = r;
		next_r.cmd_stb = 1'b0;
		next_r.acq_stb = 1'b0;
		next_r.disp_stb = 1'b0;
		next_r.nbp = 1'b0;
		next_r.pop = 1'b0;
		// power-up pulse to interfaces
		if (r.if_rst)
		begin
			if (r.cnt >= mux_pkg::POWERUP_CYCLES - 1'b1)
				next_r.if_rst = 1'b0;
			else
				next_r.cnt = r.cnt + 1'b1;
		end
		// data ready latch; set wins over done
		if (iface_data_avail)
			next_r.rdy = 1'b1;
		else if (iface_done)
			next_r.rdy = 1'b0;
		if (watchdog_timeout)
		begin
			next_r.jam = 1'b1;
			next_r.wd_seen = 1'b1;
		end
		case (r.state)
			IDLE:
			begin
				// host request always takes precedence
				if (req_f && !r.if_rst)
				begin
					next_r.ack = 1'b1;
					next_r.drive = 1'b0;
					next_r.state = HOST_ACK;
				end
				else if (r.jam && !r.if_rst)
				begin
					// status pushed without request
					next_r.send_req = 1'b1;
					next_r.fc = mux_pkg::FC_COMMAND;
					next_r.dout = status_byte(r);
					next_r.drive = 1'b1;
					next_r.is_status = 1'b1;
					next_r.state = DEV_OFFER;
				end
				else if (buf_valid && !r.pop && !r.if_rst)
				begin
					// requested data byte
					next_r.send_req = 1'b1;
					next_r.fc = mux_pkg::FC_DATA_BYTE;
					next_r.dout = buf_data;
					next_r.drive = 1'b1;
					next_r.is_status = 1'b0;
					next_r.state = DEV_OFFER;
				end
			end
			HOST_ACK:
			begin
				// wait for host data_valid
				if (dv_f)
				begin
					next_r.cnt = '0;
					next_r.sel = data_in[mux_pkg::SEL_LSB +: mux_pkg::SEL_W];
					next_r.content = data_in[mux_pkg::CONTENT_W-1:0];
					next_r.word = data_in;
					next_r.cmd_stb = (function_code_in == mux_pkg::FC_COMMAND);
					next_r.acq_stb = (function_code_in == mux_pkg::FC_ACQ_WORD);
					next_r.disp_stb = (function_code_in == mux_pkg::FC_DISPLAY_WORD);
					if (function_code_in == mux_pkg::FC_COMMAND)
						next_r.jam = 1'b1;
					next_r.state = HOST_STROBE;
				end
				else if (!req_f)
				begin
					next_r.ack = 1'b0;
					next_r.state = IDLE;
				end
			end
			HOST_STROBE:
			begin
				// strobe held for the second delay
				if (r.cnt >= mux_pkg::STROBE_CYCLES - 1'b1)
				begin
					next_r.ack = 1'b0;
					next_r.state = HOST_RELEASE;
				end
				else
				begin
					next_r.cnt = r.cnt + 1'b1;
					next_r.cmd_stb = r.cmd_stb;
					next_r.acq_stb = r.acq_stb;
					next_r.disp_stb = r.disp_stb;
				end
			end
			HOST_RELEASE:
			begin
				// host must drop request and data_valid
				if (!req_f && !dv_f)
					next_r.state = IDLE;
			end
			DEV_OFFER:
			begin
				if (ack_f)
				begin
					next_r.dv = 1'b1;
					next_r.state = DEV_HOLD;
				end
				else if (req_f)
				begin
					// host wants the bus first
					next_r.send_req = 1'b0;
					next_r.drive = 1'b0;
					next_r.state = IDLE;
				end
			end
			DEV_HOLD:
			begin
				// lines stay put until host ack falls
				if (!ack_f)
				begin
					next_r.dv = 1'b0;
					next_r.send_req = 1'b0;
					next_r.drive = 1'b0;
					next_r.state = IDLE;
					if (r.is_status && !watchdog_timeout) // timeout now keeps the jam
					begin
						next_r.jam = 1'b0;
						next_r.wd_seen = 1'b0;
					end
					if (!r.is_status)
					begin
						next_r.pop = 1'b1;
						next_r.nbp = !r.jam;
					end
				end
			end
			default:
			begin
				next_r.state = IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			r <= RESET_R; // interfaces held in reset
		else
			r <= next_r;
	end

	// pins and interface outputs, all from flops
	assign response_ack_out = r.ack;
	assign response_ack_oe = r.ack;
	assign data_valid_out = r.dv;
	assign data_valid_oe = r.drive;
	assign function_code_out = r.fc;
	assign function_code_oe = {2{r.drive}};
	assign data_out = r.dout;
	assign data_oe = {mux_pkg::DATA_W{r.drive}};
	assign device_send_request = r.send_req;
	assign cmd_strobe = r.cmd_stb;
	assign cmd_select = r.sel;
	assign cmd_content = r.content;
	assign acq_word_strobe = r.acq_stb;
	assign display_word_strobe = r.disp_stb;
	assign word_data = r.word;
	assign iface_byte_ready = buf_in_ready;
	assign next_byte_pulse = r.nbp;
	assign iface_reset = r.if_rst;
	assign data_ready = r.rdy;
	assign status_jam = r.jam;

	// protocol checks
	drivers_off_a:
		assert property (@(posedge clk) disable iff (sys_rst)
			response_ack_out |-> !data_oe[0] && !device_send_request)
		else $error("drivers on while acknowledging host");
	ack_follows_req_a:
		assert property (@(posedge clk) disable iff (sys_rst)
			$rose(req_f) && r.state == IDLE && !iface_reset |=> response_ack_out)
		else $error("no ack after filtered request");
	strobe_length_a:
		assert property (@(posedge clk) disable iff (sys_rst)
			$rose(cmd_strobe) |-> cmd_strobe [*6] ##1 !cmd_strobe && !response_ack_out)
		else $error("strobe length or ack drop wrong");
	cmd_sets_jam_a:
		assert property (@(posedge clk) disable iff (sys_rst)
			$rose(cmd_strobe) |-> status_jam)
		else $error("command did not set status_jam");
	status_code_a:
		assert property (@(posedge clk) disable iff (sys_rst)
			device_send_request && r.is_status |-> function_code_out == 2'h3)
		else $error("status sent without code 11");
	hold_steady_a:
		assert property (@(posedge clk) disable iff (sys_rst)
			data_valid_out && $past(data_valid_out) |-> $stable(data_out) && $stable(function_code_out))
		else $error("outputs changed while held");
	word_no_jam_a:
		assert property (@(posedge clk) disable iff (sys_rst)
			($rose(acq_word_strobe) || $rose(display_word_strobe)) && !$past(watchdog_timeout)
			|-> status_jam == $past(status_jam))
		else $error("full word changed status_jam");
	pulse_on_trail_a:
		assert property (@(posedge clk) disable iff (sys_rst)
			next_byte_pulse |-> $past(r.state) == DEV_HOLD && !$past(status_jam) ##1 !next_byte_pulse)
		else $error("next byte pulse out of place");
	data_code_a:
		assert property (@(posedge clk) disable iff (sys_rst)
			device_send_request && !r.is_status |-> function_code_out == 2'h0)
		else $error("data byte sent without code 00");
	reset_pulse_a:
		assert property (@(posedge clk) disable iff (sys_rst)
			$fell(iface_reset) |-> $past(sys_rst, 21) && !$past(sys_rst, 20))
		else $error("interface reset pulse length wrong");

	cmd_seen_c: cover property (@(posedge clk) disable iff (sys_rst) $rose(cmd_strobe));
	status_sent_c: cover property (@(posedge clk) disable iff (sys_rst)
		$fell(status_jam));
	byte_sent_c: cover property (@(posedge clk) disable iff (sys_rst) next_byte_pulse);
endmodule // host_device_multiplexer
`default_nettype wire

// ### pkg/mux_pkg.sv
`default_nettype none
package mux_pkg;
	// clock, filter, strobe and power-up timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int FILTER_NS = 300;
	localparam int STROBE_NS = 300;
	localparam int POWERUP_NS = 1000;
	localparam int FILTER_CYCLES_I = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYCLES_I = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POWERUP_CYCLES_I = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] FILTER_CYCLES = CNT_W'(FILTER_CYCLES_I);
	localparam logic [CNT_W-1:0] STROBE_CYCLES = CNT_W'(STROBE_CYCLES_I);
	localparam logic [CNT_W-1:0] POWERUP_CYCLES = CNT_W'(POWERUP_CYCLES_I);
	// function codes
	localparam logic [1:0] FC_COMMAND = 2'h3;
	localparam logic [1:0] FC_ACQ_WORD = 2'h1;
	localparam logic [1:0] FC_DISPLAY_WORD = 2'h0;
	localparam logic [1:0] FC_DATA_BYTE = 2'h0;
	// command byte fields
	localparam int SEL_LSB = 5;
	localparam int SEL_W = 3;
	localparam int CONTENT_W = 5;
	// status byte fields
	localparam int STAT_WATCHDOG_BIT = 7;
	localparam int STAT_READY_BIT = 6;
	localparam int DATA_W = 8;
	localparam int BUF_DEPTH = 2;
endpackage
`default_nettype wire

// ### hdl/input_filter.sv
`timescale 1ns/1ps
`default_nettype none
// three-flop synchroniser followed by a stability filter
module input_filter
(
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic raw,
	output logic      filtered
);
	typedef struct packed
	{
		logic                         s1;  // first stage, read by s2 only
		logic                         s2;
		logic                         s3;
		logic [mux_pkg::CNT_W-1:0]    cnt; // cycles of agreement seen
		logic                         out;
	} filt_s;
	filt_s r;
	filt_s next_r;

	// count agreement of stages two and three before accepting a change
	always_comb
	begin
		next_r = r;
		next_r.s1 = raw;
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
		if (r.s2 == r.s3 && r.s3 != r.out)
		begin
			if (r.cnt >= mux_pkg::FILTER_CYCLES - 1'b1)
			begin
				next_r.out = r.s3;
				next_r.cnt = '0;
			end
			else
				next_r.cnt = r.cnt + 1'b1;
		end
		else
			next_r.cnt = '0; // glitch restarts the delay
	end

	// state register
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			r <= '0;
		else
			r <= next_r;
	end

	assign filtered = r.out;
endmodule // input_filter
`default_nettype wire

// ### hdl/byte_buffer.sv
`timescale 1ns/1ps
`default_nettype none
// two-entry byte buffer with valid/ready on both sides
module byte_buffer
(
	input  wire logic                       clk,
	input  wire logic                       sys_rst,
	input  wire logic [mux_pkg::DATA_W-1:0] in_data,
	input  wire logic                       in_valid,
	output logic                            in_ready,
	output logic [mux_pkg::DATA_W-1:0]      out_data,
	output logic                            out_valid,
	input  wire logic                       out_ready
);
	typedef struct packed
	{
		logic [1:0][mux_pkg::DATA_W-1:0] mem;   // storage
		logic                            wr;    // write slot
		logic                            rd;    // read slot
		logic [1:0]                      count; // words held
		logic                            space; // registered not-full
	} buf_s;
	buf_s r;
	buf_s next_r;
	logic push;
	logic pop;

	// push and pop bookkeeping
	always_comb
	begin
		next_r = r;
		push = in_valid && r.space;
		pop = out_ready && (r.count != 2'h0);
		if (push)
		begin
			next_r.mem[r.wr] = in_data;
			next_r.wr = ~r.wr;
		end
		if (pop)
			next_r.rd = ~r.rd;
		next_r.count = r.count + {1'b0, push} - {1'b0, pop};
		next_r.space = (next_r.count != 2'(mux_pkg::BUF_DEPTH));
	end

	// state register
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			r <= '{mem: '0, wr: 1'b0, rd: 1'b0, count: 2'h0, space: 1'b1};
		else
			r <= next_r;
	end

	assign in_ready = r.space;
	assign out_data = r.mem[r.rd];
	assign out_valid = (r.count != 2'h0);
endmodule // byte_buffer
`default_nettype wire

// ### testbench/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the four-wire handshake
module host_model
(
	input  wire logic       clk,
	input  wire logic       ack_w,    // resolved acknowledge wire
	input  wire logic       dv_w,     // resolved data valid wire
	input  wire logic [1:0] fc_w,     // resolved code wires
	input  wire logic [7:0] d_w,      // resolved data wires
	input  wire logic       send_req, // device wants to send
	output logic            req,      // host send request
	output logic            ack,      // host acknowledge
	output logic            dv,       // host data valid
	output logic            drv,      // host drives code and data
	output logic [1:0]      fc,       // code from host
	output logic [7:0]      d         // byte from host
);
	// quiet lines at time zero
	initial
	begin
		req = 1'b0;
		ack = 1'b0;
		dv  = 1'b0;
		drv = 1'b0;
		fc  = 2'h0;
		d   = 8'h00;
	end

	// one byte to the device, request held until ack falls
	task automatic host_write(input logic [1:0] c, input logic [7:0] b);
		int k;
		req <= 1'b1;
		for (k = 0; k < 100 && ack_w !== 1'b1; k++)
			@(posedge clk);
		fc  <= c;
		d   <= b;
		drv <= 1'b1;
		@(posedge clk);
		dv <= 1'b1;
		for (k = 0; k < 100 && ack_w !== 1'b0; k++)
			@(posedge clk);
		req <= 1'b0;
		dv  <= 1'b0;
		drv <= 1'b0;
		repeat (20)
			@(posedge clk);
	endtask

	// one byte from the device; slow delays the ack and stretches the hold
	task automatic host_read(input int slow, output logic [1:0] c, output logic [7:0] b,
		output int moved);
		int k;
		c = 2'hX;
		b = 8'hXX;
		moved = 0;
		for (k = 0; k < 300 && send_req !== 1'b1; k++)
			@(posedge clk);
		repeat (slow)
			@(posedge clk);
		ack <= 1'b1;
		for (k = 0; k < 100 && dv_w !== 1'b1; k++)
			@(posedge clk);
		if (dv_w === 1'b1)
		begin
			c = fc_w;
			b = d_w;
		end
		// lines must not move while ack is held
		repeat (4 + slow)
		begin
			@(posedge clk);
			if (fc_w !== c || d_w !== b || dv_w !== 1'b1)
				moved++;
		end
		ack <= 1'b0;
		for (k = 0; k < 100 && dv_w !== 1'b0; k++)
			@(posedge clk);
		repeat (3)
			@(posedge clk);
	endtask
endmodule // host_model
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the host device multiplexer
module tb_top;
	logic       clk, sys_rst, wdog, avail, done, bvalid;        // bench drives
	logic       h_req, h_ack, h_dv, h_drv;                      // host drives
	logic       ack_o, ack_oe, dv_o, dv_oe, dsr, cstb, astb;    // device outputs
	logic       dstb, nbp, irst, drdy, jam, bready;             // device outputs
	logic       ack_w, dv_w;                                    // resolved wires
	logic [1:0] fc_o, fc_oe, h_fc, fc_w, c;                     // code lines
	logic [7:0] d_o, d_oe, h_d, d_w, junk, wdata, ibyte, b, r;  // byte lines
	logic [2:0] sel, sel_seen;                                  // command select
	logic [4:0] cont, cont_seen;                                // command content
	int         fail_count, tests_run, n_cmd, n_acq, n_disp, n_nbp, i, mv;

	// wire levels from every driver; released data lines churn
	assign ack_w = (ack_oe & ack_o) | h_ack;
	assign dv_w  = (dv_oe & dv_o) | h_dv;
	assign fc_w  = (fc_oe & fc_o) | (~fc_oe & (h_drv ? h_fc : junk[1:0]));
	assign d_w   = (d_oe & d_o) | (~d_oe & (h_drv ? h_d : junk));

	host_device_multiplexer i_dut
	(
		.clk(clk), .sys_rst(sys_rst), .host_send_request(h_req),
		.response_ack_in(ack_w), .response_ack_out(ack_o), .response_ack_oe(ack_oe),
		.data_valid_in(dv_w), .data_valid_out(dv_o), .data_valid_oe(dv_oe),
		.function_code_in(fc_w), .function_code_out(fc_o), .function_code_oe(fc_oe),
		.data_in(d_w), .data_out(d_o), .data_oe(d_oe), .device_send_request(dsr),
		.cmd_strobe(cstb), .cmd_select(sel), .cmd_content(cont),
		.acq_word_strobe(astb), .display_word_strobe(dstb), .word_data(wdata),
		.watchdog_timeout(wdog), .iface_data_avail(avail), .iface_done(done),
		.iface_byte(ibyte), .iface_byte_valid(bvalid), .iface_byte_ready(bready),
		.next_byte_pulse(nbp), .iface_reset(irst), .data_ready(drdy), .status_jam(jam)
	);

	host_model i_host
	(
		.clk(clk), .ack_w(ack_w), .dv_w(dv_w), .fc_w(fc_w), .d_w(d_w), .send_req(dsr),
		.req(h_req), .ack(h_ack), .dv(h_dv), .drv(h_drv), .fc(h_fc), .d(h_d)
	);

	// 50 ns clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// compare and count
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// verdict and end of run
	task automatic report_and_stop;
		$display("Checks run %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// push one byte from the sending interface
	task automatic push(input logic [7:0] v);
		int k;
		ibyte  <= v;
		bvalid <= 1'b1;
		for (k = 0; k < 50; k++)
		begin
			@(posedge clk);
			if (bready === 1'b1)
				break;
		end
		bvalid <= 1'b0;
		@(posedge clk);
	endtask

	// strobe and pulse bookkeeping, drivers off while acking
	always @(posedge clk)
	begin
		junk <= ~junk;
		if (cstb === 1'b1)
		begin
			n_cmd++;
			sel_seen  <= sel;
			cont_seen <= cont;
		end
		if (astb === 1'b1)
			n_acq++;
		if (dstb === 1'b1)
			n_disp++;
		if (nbp === 1'b1)
			n_nbp++;
		if (ack_o === 1'b1)
			check("drivers_off", 8'h00, d_oe | {5'h00, fc_oe, dv_oe});
	end

	// hang guard
	initial
	begin
		repeat (20000)
			@(posedge clk);
		fail_count++;
		report_and_stop;
	end

	// main sequence
	initial
	begin
		{sys_rst, wdog, avail, done, bvalid} = 5'h10;
		{ibyte, junk} = 16'h005A;
		{fail_count, tests_run, n_cmd, n_acq, n_disp, n_nbp} = '0;
		repeat (3)
			@(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		check("iface_reset", 8'h01, 8'(irst));
		repeat (25)
			@(posedge clk);
		check("iface_reset", 8'h00, 8'(irst));
		// every select value, status answer each time
		for (i = 0; i < 8; i++)
		begin
			b = {3'(i), 5'h0A + 5'(i)};
			i_host.host_write(mux_pkg::FC_COMMAND, b);
			check("cmd_select", 8'(b[7:5]), 8'(sel_seen));
			check("cmd_content", 8'(b[4:0]), 8'(cont_seen));
			check("cmd_strobe", 8'(mux_pkg::STROBE_CYCLES_I * (i + 1)), 8'(n_cmd));
			check("status_jam", 8'h01, 8'(jam));
			i_host.host_read(i, c, r, mv);
			check("status_code", 8'(mux_pkg::FC_COMMAND), 8'(c));
			check("status_byte", 8'({2'h0, b[7:5]}), 8'({r[7:6], r[2:0]}));
			check("status_hold", 8'h00, 8'(mv));
			check("status_jam", 8'h00, 8'(jam));
			check("next_byte", 8'h00, 8'(n_nbp));
		end
		// full words: display, acquisition, unused code
		for (i = 0; i < 3; i++)
		begin
			b = 8'hC3 ^ 8'(i);
			i_host.host_write(2'(i), b);
			check("display_strobe", 8'(mux_pkg::STROBE_CYCLES_I), 8'(n_disp));
			check("acq_strobe", 8'(i > 0 ? mux_pkg::STROBE_CYCLES_I : 0), 8'(n_acq));
			check("cmd_strobe", 8'(mux_pkg::STROBE_CYCLES_I * 8), 8'(n_cmd));
			if (i < 2)
				check("word_data", b, wdata);
			check("status_jam", 8'h00, 8'(jam));
			check("send_request", 8'h00, 8'(dsr));
		end
		// watchdog pushes status unasked
		wdog <= 1'b1;
		@(posedge clk);
		wdog <= 1'b0;
		repeat (2)
			@(posedge clk);
		check("status_jam", 8'h01, 8'(jam));
		i_host.host_read(2, c, r, mv);
		check("watchdog_code", 8'(mux_pkg::FC_COMMAND), 8'(c));
		check("watchdog_flag", 8'h01, 8'(r[7]));
		// data stream through the buffer with a stalling host
		avail <= 1'b1;
		@(posedge clk);
		avail <= 1'b0;
		repeat (2)
			@(posedge clk);
		check("data_ready", 8'h01, 8'(drdy));
		push(8'h11);
		push(8'h22);
		check("byte_ready", 8'h00, 8'(bready));
		check("send_request", 8'h01, 8'(dsr));
		for (i = 0; i < 3; i++)
		begin
			i_host.host_read(6 - 2 * i, c, r, mv);
			check("data_code", 8'(mux_pkg::FC_DATA_BYTE), 8'(c));
			check("data_byte", 8'h11 * 8'(i + 1), r);
			check("data_hold", 8'h00, 8'(mv));
			check("next_byte", 8'(i + 1), 8'(n_nbp));
			if (i == 0)
				push(8'h33);
		end
		// an offered byte gives way to a host command, status goes first
		push(8'h44);
		i_host.host_write(mux_pkg::FC_COMMAND, 8'h25);
		check("cmd_select", 8'h01, 8'(sel_seen));
		check("cmd_content", 8'h05, 8'(cont_seen));
		i_host.host_read(0, c, r, mv);
		check("status_code", 8'(mux_pkg::FC_COMMAND), 8'(c));
		check("status_byte", 8'h41, r);
		i_host.host_read(0, c, r, mv);
		check("data_code", 8'(mux_pkg::FC_DATA_BYTE), 8'(c));
		check("data_byte", 8'h44, r);
		check("next_byte", 8'h04, 8'(n_nbp));
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		repeat (3)
			@(posedge clk);
		check("data_ready", 8'h00, 8'(drdy));
		check("send_request", 8'h00, 8'(dsr));
		report_and_stop;
	end
endmodule // tb_top
`default_nettype wire
